// [design/ring_access_control_status.sv]
`timescale 1ns/1ns
`include "ring_access_params.svh"
module ring_access_control_status
	import ring_access_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  rst,
	input  wire logic  bus_wr,          // slave write strobe
	input  wire logic  bus_rd,          // slave read strobe
	input  wire logic  port_select,     // high: select port, low: value port
	input  wire word_t bus_wdata,       // write data
	input  wire logic  link_up,         // data link established
	input  wire logic  tx_frame_busy,   // frame in transmission
	input  wire logic  rx_frame_busy,   // frame in reception
	input  wire logic  poll_taken,      // tx dma acted on poll demand
	output word_t      bus_rdata_q,     // registered read data
	output logic       tx_poll_req_q,   // fetch tx ring now
	output logic       tx_ring_active_q,
	output logic       rx_ring_active_q,
	output logic       core_hold_q,     // hold internal logic reset
	output logic       send_rnr_q,      // one-cycle RNR request
	output logic       send_rr_q        // one-cycle RR request
);
	// ****************************************
	// state and storage
	// ****************************************
	word_t  select_q;                   // register select port
	phase_e phase_q;                    // stopped or running phase
	logic   poll_q;                     // poll demand waiting for the tx dma
	logic   tx_dis;                     // stored transmit ring disable
	logic   rx_dis;                     // stored receive ring disable
	logic   tx_act;                     // transmit ring on, ahead of phase gating
	logic   rx_act;                     // receive ring on, ahead of phase gating
	logic   rx_dis_prev_q;              // receive disable one cycle ago

	// ****************************************
	// address and primitive decode
	// ****************************************
	logic [2:0] sel;                    // select field of the select port
	logic       wr_select;              // host writes the select port
	logic       wr_data;                // host writes the value port
	logic       wr_main;                // value write to the main register
	logic       wr_prim;                // value write to the primitive register
	logic       start_p;                // start primitive this cycle
	logic       stop_p;                 // stop primitive this cycle
	logic       stopped;                // in the stopped phase
	logic       set_poll;               // host writes one to the poll bit

	// only the select field is decoded; the other bits are kept and read back
	assign sel       = select_q[`SEL_MSB:`SEL_LSB];
	assign wr_select = bus_wr && port_select;
	assign wr_data   = bus_wr && !port_select;
	assign wr_main   = wr_data && (sel == `SEL_MAIN_CONTROL_STATUS);
	assign wr_prim   = wr_data && (sel == `SEL_PRIMITIVE_REGISTER);
	// only the exact primitive codes act, so a stray value cannot stop the link
	assign start_p   = wr_prim && (bus_wdata == `PRIM_START);
	assign stop_p    = wr_prim && (bus_wdata == `PRIM_STOP);
	assign stopped   = (phase_q == PHASE_STOPPED);
	// a zero in the poll bit asks for nothing
	assign set_poll  = wr_main && bus_wdata[`BIT_TRANSMIT_POLL];

	// ****************************************
	// read data selection
	// ****************************************
	word_t main_word;                   // main control and status word
	word_t rd_word;                     // word of the port being read

	// status bits come from state, so writes to them cannot stick
	assign main_word = {poll_q,         // poll demand
	                    stopped,        // stopped phase, read-only
	                    tx_dis,         // transmit ring disable
	                    rx_dis,         // receive ring disable
	                    tx_act,         // transmitter on, read-only
	                    rx_act,         // receiver on, read-only
	                    10'h000};       // interrupt and error bits 9:0 live elsewhere
	// the primitive register is write only and reads as zero, like unused selects
	assign rd_word   = port_select ? select_q :
	                   ((sel == `SEL_MAIN_CONTROL_STATUS) ? main_word : 16'h0000);

	// ****************************************
	// local busy messages
	// ****************************************
	logic rx_dis_rise;                  // receive disable just set
	logic rx_dis_fall;                  // receive disable just cleared

	// edges count only while linked; with no link there is no peer to tell
	assign rx_dis_rise = rx_dis && !rx_dis_prev_q && link_up;
	assign rx_dis_fall = !rx_dis && rx_dis_prev_q && link_up;

	// ****************************************
	// ring gates
	// ****************************************
	// both rings share the write and primitive strobes, each keeps its own bit
	ring_gate u_tx (
		.core_clk   (core_clk),
		.rst        (rst),
		.disable_wr (wr_main),
		.disable_val(bus_wdata[`BIT_TX_RING_DISABLE]),
		.start_pulse(start_p),
		.stop_pulse (stop_p),
		.frame_busy (tx_frame_busy),
		.disable_q  (tx_dis),
		.active_q   (tx_act)
	);
	ring_gate u_rx (
		.core_clk   (core_clk),
		.rst        (rst),
		.disable_wr (wr_main),
		.disable_val(bus_wdata[`BIT_RX_RING_DISABLE]),
		.start_pulse(start_p),
		.stop_pulse (stop_p),
		.frame_busy (rx_frame_busy),
		.disable_q  (rx_dis),
		.active_q   (rx_act)
	);

	// ****************************************
	// next values of the outputs
	// ****************************************
	word_t rdata_d;                     // read data to capture
	logic  tx_poll_req_d;               // poll request to the tx dma
	logic  tx_ring_active_d;            // transmitter on as seen outside
	logic  rx_ring_active_d;            // receiver on as seen outside
	logic  send_rnr_d;                  // receiver not ready request
	logic  send_rr_d;                   // receiver ready request

	// read data holds between reads so a slow host sees a steady word
	assign rdata_d          = bus_rd ? rd_word : bus_rdata_q;
	// the stopped phase masks every outward request
	assign tx_poll_req_d    = poll_q && !stopped && tx_act;
	assign tx_ring_active_d = tx_act && !stopped;
	assign rx_ring_active_d = rx_act && !stopped;
	assign send_rnr_d       = rx_dis_rise && !stopped;
	assign send_rr_d        = rx_dis_fall && !stopped;

	// ****************************************
	// registers
	// ****************************************
	// select port kept until rewritten or reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			select_q <= `SELECT_RESET;
		end else if (wr_select) begin
			select_q <= bus_wdata;
		end
	end

	// phase: reset and stop enter stopped, start leaves it
	// a start while running or a stop while stopped leaves the phase alone
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase_q <= PHASE_STOPPED;
		end else begin
			case (phase_q)
				PHASE_STOPPED: if (start_p) phase_q <= PHASE_RUNNING;
				PHASE_RUNNING: if (stop_p)  phase_q <= PHASE_STOPPED;
				default:       phase_q <= PHASE_STOPPED;
			endcase
		end
	end

	// poll demand: set beats internal clear so no demand is lost
	// cleared while stopped so an old demand cannot fire after a start
	always_ff @(posedge core_clk) begin
		if (rst) begin
			poll_q <= 1'b0;
		end else if (set_poll) begin
			poll_q <= 1'b1;
		end else if (poll_taken || stopped) begin
			poll_q <= 1'b0;
		end
	end

	// read data register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus_rdata_q <= 16'h0000;
		end else begin
			bus_rdata_q <= rdata_d;
		end
	end

	// ring status outputs, all from flip-flops
	// hold comes out of reset high, matching the stopped phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_poll_req_q    <= 1'b0;
			tx_ring_active_q <= 1'b0;
			rx_ring_active_q <= 1'b0;
			core_hold_q      <= 1'b1;
		end else begin
			tx_poll_req_q    <= tx_poll_req_d;
			tx_ring_active_q <= tx_ring_active_d;
			rx_ring_active_q <= rx_ring_active_d;
			core_hold_q      <= stopped;
		end
	end

	// response pulses last one cycle, one per disable edge seen while linked and running
	// the edge history runs even when stopped, so no stale edge fires at start
	always_ff @(posedge core_clk) begin
		if (rst) begin
			send_rnr_q    <= 1'b0;
			send_rr_q     <= 1'b0;
			rx_dis_prev_q <= 1'b0;
		end else begin
			send_rnr_q    <= send_rnr_d;
			send_rr_q     <= send_rr_d;
			rx_dis_prev_q <= rx_dis;
		end
	end
endmodule : ring_access_control_status

// [design/ring_access_params.svh]
`ifndef RING_ACCESS_PARAMS_SVH
`define RING_ACCESS_PARAMS_SVH
// ****************************************
// register select and field positions
// ****************************************
`define SEL_MAIN_CONTROL_STATUS 3'h0
`define SEL_PRIMITIVE_REGISTER  3'h1
`define BIT_TRANSMIT_POLL       15
`define BIT_STOPPED             14
`define BIT_TX_RING_DISABLE     13
`define BIT_RX_RING_DISABLE     12
`define BIT_TX_RING_ACTIVE      11
`define BIT_RX_RING_ACTIVE      10
`define SEL_LSB                 1
`define SEL_MSB                 3
`define PRIM_START              16'h0001
`define PRIM_STOP               16'h0002
`define SELECT_RESET            16'h0000
`endif

// [design/ring_access_pkg.sv]
package ring_access_pkg;
	// ****************************************
	// shared types
	// ****************************************
	typedef logic [15:0] word_t;    // one port word
	typedef enum logic [1:0] {
		PHASE_STOPPED = 2'b00,         // held idle
		PHASE_RUNNING = 2'b01          // rings may run
	} phase_e;
endpackage : ring_access_pkg

// [design/ring_gate.sv]
`timescale 1ns/1ns
`include "ring_access_params.svh"
// ****************************************
// one ring: disable storage and on acknowledge
// ****************************************
module ring_gate (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic disable_wr,       // host writes disable bit
	input  wire logic disable_val,      // written value
	input  wire logic start_pulse,      // start primitive
	input  wire logic stop_pulse,       // stop primitive
	input  wire logic frame_busy,       // frame in progress on this ring
	output logic      disable_q,        // stored disable bit
	output logic      active_q          // ring-on acknowledge
);
	logic running_q;                    // between start and stop
	logic disable_d;
	logic active_d;

	// disable is plain storage
	assign disable_d = disable_wr ? disable_val : disable_q;

	// off at stop or once disable seen and frame done; on at start or disable clear, only while enabled and running
	always_comb begin
		active_d = active_q;
		if (stop_pulse) begin
			active_d = 1'b0;
		end else if (start_pulse) begin
			active_d = !disable_d;
		end else if (running_q && !disable_q) begin
			active_d = 1'b1;
		end else if (disable_q && !frame_busy) begin
			active_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			disable_q <= 1'b0;
			active_q  <= 1'b0;
			running_q <= 1'b0;
		end else begin
			disable_q <= disable_d;
			active_q  <= active_d;
			running_q <= stop_pulse ? 1'b0 : (start_pulse ? 1'b1 : running_q);
		end
	end
endmodule : ring_gate

// [test/rac_monitor.sv]
`timescale 1ns/1ns
`include "ring_access_params.svh"
module rac_monitor
	import ring_access_pkg::*;
(
	input wire logic  core_clk,
	input wire logic  rst,
	input wire logic  bus_wr,
	input wire logic  bus_rd,
	input wire logic  port_select,
	input wire word_t bus_wdata,
	input wire word_t bus_rdata_q,
	input wire logic  link_up,
	input wire logic  tx_frame_busy,
	input wire logic  rx_frame_busy,
	input wire logic  poll_taken,
	input wire logic  tx_poll_req_q,
	input wire logic  tx_ring_active_q,
	input wire logic  rx_ring_active_q,
	input wire logic  core_hold_q,
	input wire logic  send_rnr_q,
	input wire logic  send_rr_q
);
	logic [2:0] sel_q; // shadow of the select port
	always_ff @(posedge core_clk) begin
		if (rst) sel_q <= 3'h0;
		else if (bus_wr && port_select) sel_q <= bus_wdata[`SEL_MSB:`SEL_LSB];
	end
	wire vw = bus_wr && !port_select;                  // value port write
	wire pw = vw && sel_q == `SEL_MAIN_CONTROL_STATUS && bus_wdata[`BIT_TRANSMIT_POLL];
	wire sw = vw && sel_q == `SEL_PRIMITIVE_REGISTER && bus_wdata == `PRIM_START;
	wire tw = vw && sel_q == `SEL_PRIMITIVE_REGISTER && bus_wdata == `PRIM_STOP;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	hold_idle_a: assert property (
		core_hold_q && $past(core_hold_q) |-> !tx_ring_active_q && !rx_ring_active_q)
		else $error("ring on while stopped");
	poll_set_a: assert property (
		pw && tx_ring_active_q && !core_hold_q |-> ##[1:3] tx_poll_req_q)
		else $error("poll demand not raised");
	poll_cause_a: assert property (
		$rose(tx_poll_req_q) |-> $past(pw) || $past(pw, 2) || $past(pw, 3))
		else $error("poll demand without write");
	run_cause_a: assert property (
		$fell(core_hold_q) |-> $past(sw) || $past(sw, 2) || $past(sw, 3))
		else $error("left stopped phase without start");
	stop_hold_a: assert property (
		tw |-> ##[1:3] core_hold_q && !tx_ring_active_q && !rx_ring_active_q)
		else $error("stop not honoured");
	tx_busy_a: assert property (
		$fell(tx_ring_active_q) |-> !$past(tx_frame_busy) || core_hold_q)
		else $error("tx ring off in mid frame");
	rx_busy_a: assert property (
		$fell(rx_ring_active_q) |-> !$past(rx_frame_busy) || core_hold_q)
		else $error("rx ring off in mid frame");
	resp_pulse_a: assert property (
		send_rnr_q || send_rr_q |-> link_up && !(send_rnr_q && send_rr_q)
		##1 !send_rnr_q && !send_rr_q)
		else $error("bad busy response pulse");
	rdata_hold_a: assert property (
		!bus_rd |=> $stable(bus_rdata_q))
		else $error("read data moved without read");
endmodule : rac_monitor
bind ring_access_control_status rac_monitor mon (.*);

// [test/ring_host.sv]
`timescale 1ns/1ns
module ring_host
	import ring_access_pkg::*;
(
	input  wire logic core_clk,
	input  wire word_t bus_rdata_q,
	output logic      bus_wr,
	output logic      bus_rd,
	output logic      port_select,
	output word_t     bus_wdata
);
	initial begin
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		port_select = 1'b0;
		bus_wdata = 16'h0000;
	end
	// one-cycle strobe; released data inverted so no stale value lingers
	task put(input logic a, input word_t d);
		@(posedge core_clk);
		{bus_wr, port_select, bus_wdata} <= {1'b1, a, d};
		@(posedge core_clk);
		{bus_wr, bus_wdata} <= {1'b0, ~d};
	endtask : put
	task get(output word_t d);
		@(posedge core_clk);
		{bus_rd, port_select} <= 2'b10;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata_q;
	endtask : get
	// select first, then the value port
	task reg_wr(input logic [2:0] s, input word_t d);
		put(1'b1, {12'h000, s, 1'b0});
		put(1'b0, d);
	endtask : reg_wr
endmodule : ring_host

// [test/test_ring_access_control_status.sv]
`timescale 1ns/1ns
`include "ring_access_params.svh"
module test_ring_access_control_status;
	import ring_access_pkg::*;
	logic  core_clk = 1'b0, rst = 1'b1, link_up = 1'b0, poll_taken = 1'b0;
	logic  tx_frame_busy = 1'b0, rx_frame_busy = 1'b0, bus_wr, bus_rd, port_select;
	logic  tx_poll_req_q, tx_ring_active_q, rx_ring_active_q, core_hold_q, send_rnr_q, send_rr_q;
	word_t bus_wdata, bus_rdata_q, d, rnr_count = 16'h0000, rr_count = 16'h0000;
	int    err_count = 0, num_checks = 0, cyc = 0;
	wire word_t st = {12'h000, tx_poll_req_q, core_hold_q, tx_ring_active_q, rx_ring_active_q};
	ring_access_control_status uut (.*);
	ring_host host (.*);
	initial forever #4 core_clk = ~core_clk;
	// pulse counters and hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (send_rnr_q) rnr_count <= rnr_count + 16'h0001;
		if (send_rr_q) rr_count <= rr_count + 16'h0001;
		if (cyc == 3000) begin
			err_count++;
			results();
		end
	end
	task chk(input word_t seen, input word_t exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step
	task rd_main(input word_t exp);
		host.put(1'b1, 16'h0000);
		host.get(d);
		chk(d, exp);
	endtask : rd_main
	task t_stopped;
		host.reg_wr(3'h0, 16'hCFFF);
		step(3);
		chk(st, 16'h0004);
		rd_main(16'h4000);
	endtask : t_stopped
	task t_poll;
		host.reg_wr(3'h1, `PRIM_START);
		step(3);
		chk(st, 16'h0003);
		host.reg_wr(3'h0, 16'h8000);
		step(3);
		chk(st, 16'h000B);
		host.put(1'b0, 16'h0000);
		step(3);
		chk(st, 16'h000B);
		@(posedge core_clk) poll_taken <= 1'b1;
		@(posedge core_clk) poll_taken <= 1'b0;
		step(3);
		chk(st, 16'h0003);
	endtask : t_poll
	task t_tx;
		@(posedge core_clk) tx_frame_busy <= 1'b1;
		host.put(1'b0, 16'h2000);
		step(5);
		chk(st, 16'h0003);
		@(posedge core_clk) tx_frame_busy <= 1'b0;
		step(3);
		chk(st, 16'h0001);
		rd_main(16'h2400);
		host.put(1'b0, 16'h0000);
		step(3);
		chk(st, 16'h0003);
	endtask : t_tx
	task t_rx;
		@(posedge core_clk) {link_up, rx_frame_busy} <= 2'b11;
		host.put(1'b0, 16'h1000);
		step(5);
		chk(st, 16'h0003);
		@(posedge core_clk) rx_frame_busy <= 1'b0;
		step(3);
		chk(st, 16'h0002);
		host.put(1'b0, 16'h0000);
		step(3);
		chk(st, 16'h0003);
		chk({rnr_count[7:0], rr_count[7:0]}, 16'h0101);
	endtask : t_rx
	task t_stop;
		host.reg_wr(3'h1, `PRIM_STOP);
		step(3);
		chk(st, 16'h0004);
		host.get(d);
		chk(d, 16'h0000);
		rd_main(16'h4000);
	endtask : t_stop
	task results;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		t_stopped();
		t_poll();
		t_tx();
		t_rx();
		t_stop();
		results();
	end
endmodule : test_ring_access_control_status
